//--- core/ppf_consts.svh
// Constants for the parallel programming and fuse access block
`ifndef PPF_CONSTS_SVH
`define PPF_CONSTS_SVH
// Low fuse field positions
`define PPF_LO_BOD_LEVEL      7
`define PPF_LO_BOD_EN         6
`define PPF_LO_SUT_HI         5
`define PPF_LO_SUT_LO         4
`define PPF_LO_CKSEL_MSB      3
`define PPF_LO_CKSEL_LSB      0
// High fuse field positions
`define PPF_HI_RST_DIS        7
`define PPF_HI_SPI_EN         5
`define PPF_HI_OSC_OPT        4
`define PPF_HI_EE_SAVE        3
// Reset values: a programmed fuse is 0
`define PPF_FUSE_LOW_DEFAULT  8'hE1
`define PPF_FUSE_HIGH_DEFAULT 8'hD9
`define PPF_LOCK_DEFAULT      8'hFF
`define PPF_LOCK_LB1          0
`define PPF_LOCK_LB2          1
// Clock source range that selects the internal RC oscillator
`define PPF_CKSEL_RC_LO       4'h1
`define PPF_CKSEL_RC_HI       4'h4
// Identification bytes, values are arbitrary
`define PPF_SIG_0             8'hA5
`define PPF_SIG_1             8'h5A
`define PPF_SIG_2             8'h3C
// Calibration bytes for 1, 2, 4 and 8 MHz
`define PPF_CAL_1M            8'h80
`define PPF_CAL_2M            8'h81
`define PPF_CAL_4M            8'h82
`define PPF_CAL_8M            8'h83
`define PPF_BLANK_BYTE        8'hFF
// Memory geometry
`define PPF_FLASH_WORDS       4096
`define PPF_EE_BYTES          512
`define PPF_PAGE_WORDS        32
// Write cycle time and clock period
`define PPF_PROG_TIME_NS      4000
`define PPF_CLK_PERIOD_NS     4
`define PPF_PROG_CYCLES       ((`PPF_PROG_TIME_NS + `PPF_CLK_PERIOD_NS - 1) / `PPF_CLK_PERIOD_NS)
`endif

//--- core/ppf_fuse_bank.sv
// Fuse byte storage with the latched copy used by the rest of the chip
`timescale 1ns/100ps
`include "ppf_consts.svh"
module ppf_fuse_bank (
	input  wire logic clk,
	input  wire logic rst_n,
	ppf_fuse_if.bank  fif
);
	logic booted;     // High once the power-up capture has happened
	logic mode_prev;  // Programming mode one cycle ago

	// Stored fuse bytes; erase never touches them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fif.store_low  <= `PPF_FUSE_LOW_DEFAULT;
			fif.store_high <= `PPF_FUSE_HIGH_DEFAULT;
		end else begin
			if (fif.wr_low) begin
				fif.store_low <= fif.wr_data;
			end
			if (fif.wr_high) begin
				fif.store_high <= fif.wr_data;
			end
		end
	end

	// Track power-up and mode changes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			booted    <= 1'b0;
			mode_prev <= 1'b0;
		end else begin
			booted    <= 1'b1;
			mode_prev <= fif.prog_mode;
		end
	end

	// Latched copy: taken at power-up, at entry and at exit of programming mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fif.active_low  <= `PPF_FUSE_LOW_DEFAULT;
			fif.active_high <= `PPF_FUSE_HIGH_DEFAULT;
		end else if (!booted || (fif.prog_mode != mode_prev)) begin
			fif.active_low  <= fif.store_low;
			fif.active_high <= fif.store_high;
		end
	end
endmodule : ppf_fuse_bank

//--- core/ppf_fuse_if.sv
// Fuse write and fuse status signals between the port logic and the fuse bank
`timescale 1ns/100ps
interface ppf_fuse_if;
	logic       prog_mode;    // Programming mode active
	logic       wr_low;       // Write low fuse byte, one cycle
	logic       wr_high;      // Write high fuse byte, one cycle
	logic [7:0] wr_data;      // Byte to write
	logic [7:0] store_low;    // Stored low fuse byte
	logic [7:0] store_high;   // Stored high fuse byte
	logic [7:0] active_low;   // Latched low fuse byte in use
	logic [7:0] active_high;  // Latched high fuse byte in use
	modport port (output prog_mode, wr_low, wr_high, wr_data,
		input store_low, store_high, active_low, active_high);
	modport bank (input prog_mode, wr_low, wr_high, wr_data,
		output store_low, store_high, active_low, active_high);
endinterface : ppf_fuse_if

//--- core/ppf_pkg.sv
// Types for the parallel programming and fuse access block
package ppf_pkg;
	// Action on the load strobe, from the two action-select pins
	typedef enum logic [1:0] {
		PPF_ACT_ADDR = 2'h0,
		PPF_ACT_DATA = 2'h1,
		PPF_ACT_CMD  = 2'h2,
		PPF_ACT_IDLE = 2'h3
	} ppf_action_t;
	// Command byte encodings
	typedef enum logic [7:0] {
		PPF_CMD_ERASE    = 8'h80,
		PPF_CMD_WR_FUSE  = 8'h40,
		PPF_CMD_WR_LOCK  = 8'h20,
		PPF_CMD_WR_FLASH = 8'h10,
		PPF_CMD_WR_EE    = 8'h11,
		PPF_CMD_RD_SIG   = 8'h08,
		PPF_CMD_RD_FUSE  = 8'h04,
		PPF_CMD_RD_FLASH = 8'h02,
		PPF_CMD_RD_EE    = 8'h03
	} ppf_cmd_t;
	// Write engine state
	typedef enum logic {PPF_READY, PPF_BUSY} ppf_state_t;
endpackage : ppf_pkg

//--- core/ppf_port.sv
// Parallel programming port with flash, eeprom, lock, fuse and signature access
// What this block does
// - Low fuse: level, enable, start-up, clock fields
// - Low fuse default leaves brown-out detector off
// - Default: internal RC 1MHz, longest start-up
// - Oscillator option meaning depends on clock source
// - Chip erase leaves fuses unchanged
// - Lock bit one programmed refuses fuse writes
// - Fuses latched at mode entry, effective after exit
// - Eeprom preserve fuse acts immediately
// - Fuses also latched at power-up
// - Serial enable fuse unreachable by serial programming
// - Reset-disable fuse: changes only via parallel port
// - Three identification bytes, readable even when locked
// - Four calibration bytes for 1,2,4,8 MHz
// - Reset loads 1MHz calibration into calibration register
// - Flash: 128 pages of 32 words
// - Eeprom: 128 pages of 4 bytes
// - Load strobe acts on action-select pins
// - Write/read strobes perform last loaded command
// - Decode the nine command bytes
// - Ready/busy low while programming in progress
// - Byte selects choose low or high bytes
// - Write and read strobes active low; drive bus only when reading
// - Programmed fuse reads 0, unprogrammed 1
// - Command and address retained across operations
`timescale 1ns/100ps
`include "ppf_consts.svh"
module ppf_port (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       prog_enter,
	input  wire logic       crystal_in_strobe,
	input  wire logic       action_select_0,
	input  wire logic       action_select_1,
	input  wire logic       byte_select_one,
	input  wire logic       byte_select_two,
	input  wire logic       page_load_strobe,
	input  wire logic       oe_n,
	input  wire logic       wr_n,
	input  wire logic [7:0] data_in,
	input  wire logic       cal_wr_en,
	input  wire logic [7:0] cal_wr_data,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            ready_busy_out,
	output logic      [7:0] osc_calibration_reg,
	output logic      [7:0] fuse_low_active,
	output logic      [7:0] fuse_high_active,
	output logic            eeprom_preserve_active,
	output logic      [7:0] lock_bits_out,
	output logic            osc_option_applied
);
	// Synchronised pins
	logic [16:0]       pins_s;          // All pins after two flops
	logic              s_prog;          // Programming mode request
	logic              s_xtal;          // Load strobe
	logic [1:0]        s_action;        // Action select pair
	logic              s_bs1;           // Byte select one
	logic              s_bs2;           // Byte select two
	logic              s_page_load_strobe;         // Page load strobe
	logic              s_oe_n;          // Output enable, active low
	logic              s_wr_n;          // Write strobe, active low
	logic [7:0]        s_data;          // Data bus from the programmer
	// Edge detection
	logic              xtal_prev;       // Load strobe one cycle ago
	logic              page_load_strobe_prev;      // Page load one cycle ago
	logic              wr_n_prev;       // Write strobe one cycle ago
	logic              xtal_rise;       // Load strobe rising edge
	logic              page_load_strobe_rise;      // Page load rising edge
	logic              wr_fall;         // Write strobe falling edge
	// Loaded registers
	logic [7:0]        cmd;             // Last command byte
	logic [7:0]        addr_lo;         // Address low byte
	logic [7:0]        addr_hi;         // Address high byte
	logic [7:0]        data_lo;         // Data low byte
	logic [7:0]        data_hi;         // Data high byte
	logic [7:0]        lock_bits;       // Lock byte, 0 means programmed
	// Write engine
	ppf_pkg::ppf_state_t state;         // Ready or busy
	logic [11:0]       busy_cnt;        // Cycles left in the write
	// Storage
	logic [15:0]       flash_mem [0:`PPF_FLASH_WORDS-1];  // Program memory
	logic [7:0]        ee_mem    [0:`PPF_EE_BYTES-1];     // Data memory
	logic [15:0]       page_buf  [0:`PPF_PAGE_WORDS-1];   // Page buffer
	// Decoded strobes
	logic              start_op;        // Accept a write strobe
	logic              lb1_set;         // Lock bit one programmed
	logic              verify_off;      // Both lock bits programmed
	logic              fuse_wr_ok;      // Fuse write allowed
	logic [7:0]        next_data_out;   // Byte for the data bus

	ppf_fuse_if fif ();

	// Pins pass two flops before any logic reads them
	ppf_sync #(.W(17)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   ({prog_enter, crystal_in_strobe, action_select_1, action_select_0,
			byte_select_one, byte_select_two, page_load_strobe, oe_n, wr_n, data_in}),
		.dout  (pins_s)
	);

	assign s_prog   = pins_s[16];
	assign s_xtal   = pins_s[15];
	assign s_action = pins_s[14:13];
	assign s_bs1    = pins_s[12];
	assign s_bs2    = pins_s[11];
	assign s_page_load_strobe  = pins_s[10];
	assign s_oe_n   = pins_s[9];
	assign s_wr_n   = pins_s[8];
	assign s_data   = pins_s[7:0];

	ppf_fuse_bank u_bank (
		.clk   (clk),
		.rst_n (rst_n),
		.fif   (fif)
	);

	// Flash word address from the two address bytes; page in bits 11:5
	function automatic logic [11:0] flash_word(input logic [7:0] hi, input logic [7:0] lo);
		flash_word = {hi[3:0], lo};
	endfunction : flash_word

	// Eeprom byte address from the two address bytes; page in bits 8:2
	function automatic logic [8:0] ee_byte(input logic [7:0] hi, input logic [7:0] lo);
		ee_byte = {hi[0], lo};
	endfunction : ee_byte

	// Edge detectors on synchronised strobes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xtal_prev  <= 1'b0;
			page_load_strobe_prev <= 1'b0;
			wr_n_prev  <= 1'b1;
		end else begin
			xtal_prev  <= s_xtal;
			page_load_strobe_prev <= s_page_load_strobe;
			wr_n_prev  <= s_wr_n;
		end
	end

	assign xtal_rise  = s_xtal & ~xtal_prev & s_prog & (state == ppf_pkg::PPF_READY);
	assign page_load_strobe_rise = s_page_load_strobe & ~page_load_strobe_prev & s_prog & (state == ppf_pkg::PPF_READY);
	assign wr_fall    = ~s_wr_n & wr_n_prev & s_prog;
	assign start_op   = wr_fall & (state == ppf_pkg::PPF_READY);
	assign lb1_set    = ~lock_bits[`PPF_LOCK_LB1];
	assign verify_off = lb1_set & ~lock_bits[`PPF_LOCK_LB2];
	assign fuse_wr_ok = start_op & (cmd == ppf_pkg::PPF_CMD_WR_FUSE) & ~lb1_set;

	// Fuse writes go to the bank; the only path to any fuse is this port
	assign fif.prog_mode = s_prog;
	assign fif.wr_low    = fuse_wr_ok & ~s_bs1;
	assign fif.wr_high   = fuse_wr_ok & s_bs1;
	assign fif.wr_data   = data_lo;

	// Loads on the load strobe; values are kept until overwritten
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd     <= 8'h00;
			addr_lo <= 8'h00;
			addr_hi <= 8'h00;
			data_lo <= `PPF_BLANK_BYTE;
			data_hi <= `PPF_BLANK_BYTE;
		end else if (xtal_rise) begin
			case (ppf_pkg::ppf_action_t'(s_action))
				ppf_pkg::PPF_ACT_ADDR: begin
					if (s_bs1) begin
						addr_hi <= s_data;
					end else begin
						addr_lo <= s_data;
					end
				end
				ppf_pkg::PPF_ACT_DATA: begin
					if (s_bs1) begin
						data_hi <= s_data;
					end else begin
						data_lo <= s_data;
					end
				end
				ppf_pkg::PPF_ACT_CMD: begin
					cmd <= s_data;
				end
				default: begin
					// Idle action: nothing loads
				end
			endcase
		end
	end

	// Page buffer filled on each page load edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `PPF_PAGE_WORDS; i++) begin
				page_buf[i] <= {`PPF_BLANK_BYTE, `PPF_BLANK_BYTE};
			end
		end else if (page_load_strobe_rise) begin
			if (cmd == ppf_pkg::PPF_CMD_WR_EE) begin
				page_buf[{3'h0, addr_lo[1:0]}] <= {`PPF_BLANK_BYTE, data_lo};
			end else begin
				page_buf[addr_lo[4:0]] <= {data_hi, data_lo};
			end
		end
	end

	// Write engine: busy for the write cycle after each accepted strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= ppf_pkg::PPF_READY;
			busy_cnt <= 12'h000;
		end else begin
			case (state)
				ppf_pkg::PPF_READY: begin
					if (start_op) begin
						state    <= ppf_pkg::PPF_BUSY;
						busy_cnt <= 12'(`PPF_PROG_CYCLES - 1);
					end
				end
				ppf_pkg::PPF_BUSY: begin
					if (busy_cnt == 12'h000) begin
						state <= ppf_pkg::PPF_READY;
					end else begin
						busy_cnt <= busy_cnt - 12'h001;
					end
				end
				default: begin
					state <= ppf_pkg::PPF_READY;
				end
			endcase
		end
	end

	// Ready/busy pin is low for the whole write cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_busy_out <= 1'b1;
		end else begin
			ready_busy_out <= ~(start_op | ((state == ppf_pkg::PPF_BUSY) &&
				(busy_cnt != 12'h000)));
		end
	end

	// Lock bits: write can only program; chip erase clears them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_bits <= `PPF_LOCK_DEFAULT;
		end else if (start_op && (cmd == ppf_pkg::PPF_CMD_ERASE)) begin
			lock_bits <= `PPF_LOCK_DEFAULT;
		end else if (start_op && (cmd == ppf_pkg::PPF_CMD_WR_LOCK)) begin
			lock_bits <= lock_bits & data_lo;
		end
	end

	// Program memory: erase to blank, page write when not locked
	always_ff @(posedge clk) begin
		if (start_op && (cmd == ppf_pkg::PPF_CMD_ERASE)) begin
			for (int i = 0; i < `PPF_FLASH_WORDS; i++) begin
				flash_mem[i] <= {`PPF_BLANK_BYTE, `PPF_BLANK_BYTE};
			end
		end else if (start_op && (cmd == ppf_pkg::PPF_CMD_WR_FLASH) && !lb1_set) begin
			for (int i = 0; i < `PPF_PAGE_WORDS; i++) begin
				flash_mem[flash_word(addr_hi, {addr_lo[7:5], 5'(i)})] <= page_buf[i];
			end
		end
	end

	// Data memory: erase unless preserved, page write when not locked
	always_ff @(posedge clk) begin
		if (start_op && (cmd == ppf_pkg::PPF_CMD_ERASE) && !eeprom_preserve_active) begin
			for (int i = 0; i < `PPF_EE_BYTES; i++) begin
				ee_mem[i] <= `PPF_BLANK_BYTE;
			end
		end else if (start_op && (cmd == ppf_pkg::PPF_CMD_WR_EE) && !lb1_set) begin
			for (int i = 0; i < 4; i++) begin
				ee_mem[ee_byte(addr_hi, {addr_lo[7:2], 2'(i)})] <= page_buf[i][7:0];
			end
		end
	end

	// Read multiplexer for the current command and byte selects
	always_comb begin
		next_data_out = `PPF_BLANK_BYTE;
		case (cmd)
			ppf_pkg::PPF_CMD_RD_SIG: begin
				if (s_bs1) begin
					if (addr_lo[1:0] == 2'h0) begin
						next_data_out = `PPF_CAL_1M;
					end else if (addr_lo[1:0] == 2'h1) begin
						next_data_out = `PPF_CAL_2M;
					end else if (addr_lo[1:0] == 2'h2) begin
						next_data_out = `PPF_CAL_4M;
					end else begin
						next_data_out = `PPF_CAL_8M;
					end
				end else if (addr_lo[1:0] == 2'h0) begin
					next_data_out = `PPF_SIG_0;
				end else if (addr_lo[1:0] == 2'h1) begin
					next_data_out = `PPF_SIG_1;
				end else if (addr_lo[1:0] == 2'h2) begin
					next_data_out = `PPF_SIG_2;
				end
			end
			ppf_pkg::PPF_CMD_RD_FUSE: begin
				if (s_bs1 && s_bs2) begin
					next_data_out = fif.store_high;
				end else if (s_bs1) begin
					next_data_out = lock_bits;
				end else begin
					next_data_out = fif.store_low;
				end
			end
			ppf_pkg::PPF_CMD_RD_FLASH: begin
				if (!verify_off) begin
					next_data_out = s_bs1 ? flash_mem[flash_word(addr_hi, addr_lo)][15:8]
						: flash_mem[flash_word(addr_hi, addr_lo)][7:0];
				end
			end
			ppf_pkg::PPF_CMD_RD_EE: begin
				if (!verify_off) begin
					next_data_out = ee_mem[ee_byte(addr_hi, addr_lo)];
				end
			end
			default: begin
				next_data_out = `PPF_BLANK_BYTE;
			end
		endcase
	end

	// Bus is driven only while output enable is low in programming mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 8'h00;
			data_oe  <= 1'b0;
		end else begin
			data_out <= next_data_out;
			data_oe  <= s_prog & ~s_oe_n;
		end
	end

	// Calibration register: 1MHz value at reset, software may reload it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_calibration_reg <= `PPF_CAL_1M;
		end else if (cal_wr_en) begin
			osc_calibration_reg <= cal_wr_data;
		end
	end

	// Status outputs registered; fuse bytes from the latched fuse copy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fuse_low_active        <= `PPF_FUSE_LOW_DEFAULT;
			fuse_high_active       <= `PPF_FUSE_HIGH_DEFAULT;
			eeprom_preserve_active <= 1'b0;
			lock_bits_out          <= `PPF_LOCK_DEFAULT;
			osc_option_applied     <= 1'b0;
		end else begin
			fuse_low_active        <= fif.active_low;
			fuse_high_active       <= fif.active_high;
			// Preserve fuse bypasses the latch
			eeprom_preserve_active <= ~fif.store_high[`PPF_HI_EE_SAVE];
			lock_bits_out          <= lock_bits;
			// Option fuse has no meaning while the internal RC is selected
			osc_option_applied     <= ~fif.active_high[`PPF_HI_OSC_OPT] &
				((fif.active_low[`PPF_LO_CKSEL_MSB:`PPF_LO_CKSEL_LSB] < `PPF_CKSEL_RC_LO) |
				(fif.active_low[`PPF_LO_CKSEL_MSB:`PPF_LO_CKSEL_LSB] > `PPF_CKSEL_RC_HI));
		end
	end
endmodule : ppf_port

//--- core/ppf_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module ppf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;  // First stage, read only by the second

	// Both stages clear to zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : ppf_sync

//--- tb/ppf_port_props.sv
// Concurrent checks on the programming port top-level ports
`timescale 1ns/100ps
`include "ppf_consts.svh"
module ppf_port_props (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       prog_enter,
	input wire logic       oe_n,
	input wire logic       wr_n,
	input wire logic       cal_wr_en,
	input wire logic [7:0] cal_wr_data,
	input wire logic       data_oe,
	input wire logic       ready_busy_out,
	input wire logic [7:0] osc_calibration_reg,
	input wire logic [7:0] fuse_low_active,
	input wire logic [7:0] fuse_high_active,
	input wire logic       osc_option_applied
);
	int   busy_cnt; // Cycles spent busy so far
	logic opt_exp;  // Expected oscillator option outcome
	// Count busy cycles, cleared while ready
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= ready_busy_out ? 0 : busy_cnt + 1;
		end
	end
	// Option counts only outside the internal RC clock range
	assign opt_exp = !fuse_high_active[`PPF_HI_OSC_OPT] &&
		(fuse_low_active[3:0] < `PPF_CKSEL_RC_LO || fuse_low_active[3:0] > `PPF_CKSEL_RC_HI);
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_read_drives_bus: assert property (($fell(oe_n) && prog_enter && $past(prog_enter, 6)
		&& ready_busy_out) |-> ##[1:4] data_oe) else $error("bus not driven on read");
	a_bus_released: assert property ($rose(oe_n) |-> ##[1:4] !data_oe)
		else $error("bus not released");
	a_idle_no_drive: assert property (oe_n [*6] |-> !data_oe)
		else $error("bus driven while not reading");
	a_busy_length: assert property ($rose(ready_busy_out) |-> busy_cnt == `PPF_PROG_CYCLES)
		else $error("busy time wrong");
	a_busy_from_wr: assert property ($fell(ready_busy_out) |-> prog_enter &&
		(!$past(wr_n, 2) || !$past(wr_n, 3) || !$past(wr_n, 4))) else $error("busy without strobe");
	a_cal_load: assert property (cal_wr_en |=> osc_calibration_reg == $past(cal_wr_data))
		else $error("calibration not loaded");
	a_cal_keep: assert property (!cal_wr_en |=> $stable(osc_calibration_reg))
		else $error("calibration changed");
	a_fuse_latched: assert property ((prog_enter && $past(prog_enter, 6)) |->
		$stable(fuse_low_active) && $stable(fuse_high_active)) else $error("fuses moved in mode");
	a_osc_option: assert property (($stable(fuse_low_active) && $stable(fuse_high_active))
		|-> osc_option_applied == opt_exp) else $error("option outcome wrong");
endmodule : ppf_port_props

//--- tb/ppf_prog_model.sv
// Behavioural parallel programmer driving the port pins
`timescale 1ns/100ps
module ppf_prog_model (
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	input  wire logic       ready_busy_out,
	output logic            prog_enter,
	output logic            crystal_in_strobe,
	output logic            action_select_0,
	output logic            action_select_1,
	output logic            byte_select_one,
	output logic            byte_select_two,
	output logic            page_load_strobe,
	output logic            oe_n,
	output logic            wr_n,
	output logic      [7:0] data_in
);
	logic [7:0] drv; // Byte the programmer puts on the bus
	// Bus level: the device wins only while it drives
	assign data_in = data_oe ? data_out : drv;
	// Idle pin levels from time zero
	initial begin
		{prog_enter, crystal_in_strobe, page_load_strobe} = 3'h0;
		{action_select_1, action_select_0, byte_select_one, byte_select_two, oe_n, wr_n} = 6'h33;
		drv = 8'h00;
	end
	// Hold a level long enough for the pin synchronisers
	task gap;
		repeat (5) @(negedge clk);
	endtask : gap
	// Enter or leave programming mode
	task mode(input logic on);
		prog_enter = on;
		gap();
	endtask : mode
	// Load address, data or command on a load strobe pulse
	task load(input logic [1:0] act, input logic bs1, input logic [7:0] b);
		{action_select_1, action_select_0} = act;
		byte_select_one = bs1;
		drv = b;
		gap();
		crystal_in_strobe = 1'b1;
		gap();
		crystal_in_strobe = 1'b0;
		gap();
	endtask : load
	// Store the loaded data word into the page buffer
	task page_load;
		page_load_strobe = 1'b1;
		gap();
		page_load_strobe = 1'b0;
		gap();
	endtask : page_load
	// Active-low write strobe runs the loaded command
	task write_pulse(input logic bs1);
		byte_select_one = bs1;
		wr_n = 1'b0;
		gap();
		wr_n = 1'b1;
		gap();
	endtask : write_pulse
	// Read one byte with output enable held low
	task read(input logic bs1, input logic bs2, output logic [7:0] d);
		{byte_select_one, byte_select_two} = {bs1, bs2};
		oe_n = 1'b0;
		gap();
		d = data_in;
		oe_n = 1'b1;
		gap();
	endtask : read
	// No new action until the device reports ready
	task wait_ready(output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 1200 && !ok; i++) begin
			ok = (ready_busy_out === 1'b1);
			@(negedge clk);
		end
	endtask : wait_ready
endmodule : ppf_prog_model

//--- tb/tb_ppf_port.sv
// Self-checking bench for the parallel programming port
`timescale 1ns/100ps
`include "ppf_consts.svh"
module tb_ppf_port;
	logic       clk, rst_n, cal_wr_en, prog_enter, crystal_in_strobe, osc_option_applied;
	logic       action_select_0, action_select_1, byte_select_one, byte_select_two;
	logic       page_load_strobe, oe_n, wr_n, data_oe, ready_busy_out, eeprom_preserve_active;
	logic [7:0] cal_wr_data, data_in, data_out, osc_calibration_reg;
	logic [7:0] fuse_low_active, fuse_high_active, lock_bits_out;
	int         n_errors;    // Mismatches seen
	int         check_count; // Comparisons made
	localparam logic [1:0] act_a = ppf_pkg::PPF_ACT_ADDR; // Address load
	localparam logic [1:0] act_d = ppf_pkg::PPF_ACT_DATA; // Data load
	localparam logic [1:0] act_c = ppf_pkg::PPF_ACT_CMD;  // Command load
	logic [7:0] sig_exp [4] = '{`PPF_SIG_0, `PPF_SIG_1, `PPF_SIG_2, `PPF_BLANK_BYTE};
	logic [7:0] cal_exp [4] = '{`PPF_CAL_1M, `PPF_CAL_2M, `PPF_CAL_4M, `PPF_CAL_8M};
	// Design and programmer
	ppf_port u_dut (.clk, .rst_n, .prog_enter, .crystal_in_strobe, .action_select_0,
		.action_select_1, .byte_select_one, .byte_select_two, .page_load_strobe, .oe_n,
		.wr_n, .data_in, .cal_wr_en, .cal_wr_data, .data_out, .data_oe, .ready_busy_out,
		.osc_calibration_reg, .fuse_low_active, .fuse_high_active, .eeprom_preserve_active,
		.lock_bits_out, .osc_option_applied);
	ppf_prog_model u_prog (.clk, .data_out, .data_oe, .ready_busy_out, .prog_enter,
		.crystal_in_strobe, .action_select_0, .action_select_1, .byte_select_one,
		.byte_select_two, .page_load_strobe, .oe_n, .wr_n, .data_in);
	// 4 ns clock
	initial clk = 1'b0;
	always #2 clk = ~clk;
	// Compare and count
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	// Print counts and verdict, then stop
	task close_out;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	// Write strobe, optional busy check, bounded wait for ready
	task wr(input logic bs1, input logic busy);
		logic ok;
		u_prog.write_pulse(bs1);
		if (busy) chk({7'h00, ready_busy_out}, 8'h00, "not busy");
		u_prog.wait_ready(ok);
		if (!ok) begin
			n_errors++;
			close_out();
		end
	endtask : wr
	// Read a byte and compare
	task rd(input logic bs1, input logic bs2, input logic [7:0] e);
		logic [7:0] d;
		u_prog.read(bs1, bs2, d);
		chk(d, e, "read byte");
	endtask : rd
	// Main sequence
	initial begin
		{rst_n, cal_wr_en, cal_wr_data, n_errors, check_count} = '0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		chk(fuse_low_active, 8'hE1, "low fuse default");
		chk(fuse_high_active, 8'hD9, "high fuse default");
		chk(osc_calibration_reg, `PPF_CAL_1M, "reset calibration");
		chk({7'h00, osc_option_applied}, 8'h00, "option default");
		{cal_wr_en, cal_wr_data} = 9'h15C;
		@(negedge clk);
		cal_wr_en = 1'b0;
		@(negedge clk);
		chk(osc_calibration_reg, 8'h5C, "software calibration");
		$display("test reset done");
		u_prog.mode(1'b1);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_SIG);
		for (int i = 0; i < 4; i++) begin
			u_prog.load(act_a, 1'b0, 8'(i));
			rd(1'b0, 1'b0, sig_exp[i]);
			rd(1'b1, 1'b0, cal_exp[i]);
		end
		$display("test signature done");
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_WR_FUSE);
		u_prog.load(act_d, 1'b0, 8'hE0);
		wr(1'b0, 1'b1);
		u_prog.load(act_d, 1'b0, 8'hC1);
		wr(1'b1, 1'b1);
		chk({7'h00, eeprom_preserve_active}, 8'h01, "preserve late");
		chk(fuse_low_active, 8'hE1, "low fuse moved");
		chk(fuse_high_active, 8'hD9, "high fuse moved");
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_FUSE);
		rd(1'b0, 1'b0, 8'hE0);
		rd(1'b1, 1'b1, 8'hC1);
		rd(1'b1, 1'b0, 8'hFF);
		u_prog.mode(1'b0);
		chk(fuse_low_active, 8'hE0, "low fuse after exit");
		chk(fuse_high_active, 8'hC1, "high fuse after exit");
		chk({7'h00, osc_option_applied}, 8'h01, "option applied");
		u_prog.mode(1'b1);
		$display("test fuses done");
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_WR_EE);
		u_prog.load(act_a, 1'b0, 8'h05);
		u_prog.load(act_a, 1'b1, 8'h00);
		u_prog.load(act_d, 1'b0, 8'h3C);
		u_prog.page_load();
		wr(1'b0, 1'b1);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_WR_FLASH);
		u_prog.load(act_a, 1'b0, 8'h21);
		u_prog.load(act_d, 1'b0, 8'h12);
		u_prog.load(act_d, 1'b1, 8'h34);
		u_prog.page_load();
		wr(1'b0, 1'b1);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_FLASH);
		rd(1'b0, 1'b0, 8'h12);
		rd(1'b1, 1'b0, 8'h34);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_EE);
		u_prog.load(act_a, 1'b0, 8'h05);
		rd(1'b0, 1'b0, 8'h3C);
		$display("test memories done");
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_ERASE);
		wr(1'b0, 1'b1);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_EE);
		rd(1'b0, 1'b0, 8'h3C);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_FLASH);
		u_prog.load(act_a, 1'b0, 8'h21);
		rd(1'b0, 1'b0, 8'hFF);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_FUSE);
		rd(1'b0, 1'b0, 8'hE0);
		$display("test erase done");
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_WR_LOCK);
		u_prog.load(act_d, 1'b0, 8'hFE);
		wr(1'b0, 1'b1);
		chk(lock_bits_out, 8'hFE, "lock output");
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_WR_FUSE);
		u_prog.load(act_d, 1'b0, 8'hFF);
		wr(1'b0, 1'b0);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_FUSE);
		rd(1'b1, 1'b0, 8'hFE);
		rd(1'b0, 1'b0, 8'hE0);
		u_prog.load(act_c, 1'b0, ppf_pkg::PPF_CMD_RD_SIG);
		u_prog.load(act_a, 1'b0, 8'h00);
		rd(1'b0, 1'b0, sig_exp[0]);
		$display("test lock done");
		close_out();
	end
endmodule : tb_ppf_port
bind ppf_port ppf_port_props u_props (.clk, .rst_n, .prog_enter, .oe_n, .wr_n, .cal_wr_en,
	.cal_wr_data, .data_oe, .ready_busy_out, .osc_calibration_reg, .fuse_low_active,
	.fuse_high_active, .osc_option_applied);
